// ### rtl/ebl_pkg.sv
package ebl_pkg;

   // register word offsets (byte addresses on the bus)
   localparam logic [11:0] OFS_CAP        = 12'h000;
   localparam logic [11:0] OFS_GSTAT      = 12'h004;
   localparam logic [11:0] OFS_IRQ_STAT   = 12'h008;
   localparam logic [11:0] OFS_IRQ_MASK   = 12'h00c;
   localparam logic [11:0] OFS_CTRL       = 12'h010;
   localparam logic [11:0] OFS_BANK_BASE  = 12'h400;
   localparam logic [11:0] OFS_BANK_STEP  = 12'h010;
   localparam logic [11:0] OFS_BANK_STAT  = 12'h000;
   localparam logic [11:0] OFS_BANK_ADDR  = 12'h004;
   localparam logic [11:0] OFS_BANK_EXTRA = 12'h008;

   // bank status field positions
   localparam int BIT_ENTRY_GOOD  = 31;
   localparam int BIT_LOST_ERROR  = 30;
   localparam int BIT_UNCORRECTED = 29;
   localparam int BIT_EXTRA_GOOD  = 27;
   localparam int BIT_ADDR_GOOD   = 26;
   localparam int BIT_CTX_CORRUPT = 25;
   localparam int CODE_W          = 16;

   // global status field positions
   localparam int BIT_RESTART_IP_GOOD = 0;
   localparam int BIT_CHECK_IN_PROG   = 2;
   localparam int BIT_SHUTDOWN        = 3;

   // interrupt status bits
   localparam int IRQ_CORRECTED = 0;
   localparam int IRQ_CHECK     = 1;
   localparam int IRQ_SHUTDOWN  = 2;
   localparam int IRQ_W         = 3;

   localparam logic [31:0] RST_WORD = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED = 32'h0000_0000;

   typedef struct packed {
      logic        uncorrected;
      logic        ctx_corrupt;
      logic        addr_good;
      logic        extra_good;
      logic [15:0] code;
      logic [31:0] addr;
      logic [31:0] extra;
   } ebl_err_s;

   typedef enum logic [1:0] {
      ST_RUN      = 2'b00,
      ST_CHECK    = 2'b01,
      ST_SHUTDOWN = 2'b10
   } ebl_state_e;

endpackage

// ### rtl/ebl_bank.sv
`timescale 1ns/1ns
module ebl_bank
   import ebl_pkg::*;
#(
   parameter int DEPTH = 2
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        rst_n,
   // error capture
   input  wire logic        err_valid,
   input  wire ebl_err_s    err_in,
   // software side
   input  wire logic        stat_wr,
   input  wire logic [31:0] wdata,
   output logic [31:0]      stat_word,
   output logic [31:0]      addr_word,
   output logic [31:0]      extra_word,
   output logic             entry_good
);
   // held entry plus a small queue of later errors
   ebl_err_s                 held;
   logic                     entry_good_flag;
   logic                     lost_error_flag;
   ebl_err_s                 queue [DEPTH];
   logic [$clog2(DEPTH+1)-1:0] count;

   wire clear_req  = stat_wr && (wdata == RST_WORD);
   wire slot_free  = !entry_good_flag || clear_req;
   wire from_queue = slot_free && (count != '0);
   wire direct     = slot_free && (count == '0) && err_valid;
   wire push       = err_valid && !direct;
   wire q_full     = (count == DEPTH[$bits(count)-1:0]);
   wire do_push    = push && (!q_full || from_queue);

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         entry_good_flag <= 1'b0;
         lost_error_flag <= 1'b0;
         held            <= '0;
         count           <= '0;
      end else begin
         // content holds until cleared or replaced
         if (from_queue) begin
            held            <= queue[0];
            entry_good_flag <= 1'b1;
         end else if (direct) begin
            held            <= err_in;
            entry_good_flag <= 1'b1;
         end else if (clear_req) begin
            // zeros written read back as zeros, address and extra words too
            held            <= '0;
            entry_good_flag <= 1'b0;
         end
         // a new overflow wins over the clear
         if (push && q_full && !from_queue)
            lost_error_flag <= 1'b1;
         else if (clear_req)
            lost_error_flag <= 1'b0;
         count <= count - $bits(count)'(from_queue) + $bits(count)'(do_push);
      end
   end

   // shift queue; storage has no reset, only count matters
   always_ff @(posedge clk) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (from_queue)
            queue[i] <= (i + 1 < DEPTH) ? queue[(i + 1) % DEPTH] : queue[i];
      end
      if (do_push)
         queue[int'(count) - (from_queue ? 1 : 0)] <= err_in;
   end

   always_comb begin
      stat_word                  = '0;
      stat_word[BIT_ENTRY_GOOD]  = entry_good_flag;
      stat_word[BIT_LOST_ERROR]  = lost_error_flag;
      stat_word[BIT_UNCORRECTED] = held.uncorrected;
      stat_word[BIT_EXTRA_GOOD]  = held.extra_good;
      stat_word[BIT_ADDR_GOOD]   = held.addr_good;
      stat_word[BIT_CTX_CORRUPT] = held.ctx_corrupt;
      stat_word[CODE_W-1:0]      = held.code;
   end

   assign addr_word  = held.addr;
   assign extra_word = held.extra;
   assign entry_good = entry_good_flag;

endmodule

// ### rtl/ebl_check.sv
`timescale 1ns/1ns
module ebl_check
   import ebl_pkg::*;
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // raise and software clear
   input  wire logic raise,
   input  wire logic clear_in_prog,
   // state
   output logic      in_prog,
   output logic      shutdown,
   output logic      take_exc
);
   ebl_state_e state;
   ebl_state_e next_state;

   // recursion is unsupported, so a second raise stops the core
   always_comb begin
      next_state = state;
      case (state)
         ST_RUN:      next_state = raise ? ST_CHECK : ST_RUN;
         ST_CHECK: begin
            if (raise)
               next_state = ST_SHUTDOWN;
            else if (clear_in_prog)
               next_state = ST_RUN;
         end
         ST_SHUTDOWN: next_state = ST_SHUTDOWN;
         default:     next_state = ST_RUN;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!rst_n)
         state <= ST_RUN;
      else
         state <= next_state;
   end

   assign in_prog  = (state == ST_CHECK);
   assign shutdown = (state == ST_SHUTDOWN);
   assign take_exc = raise && (state == ST_RUN);

endmodule

// ### rtl/ebl_top.sv
// Local design decisions: the Avalon-MM register port and the register addresses.
`timescale 1ns/1ns
// Function
// - correctable errors are logged and raise the corrected interrupt, never the check exception.
// - entry_good_flag marks a bank holding a recorded error.
// - address_good_flag marks the address register as meaningful.
// - extra_info_good_flag marks the extra register as meaningful.
// - check_in_progress_flag stays set while the exception is serviced.
// - restartable only with context_corrupt clear and restart_ip_good set.
// - writing zeros clears lost_error_flag and entry_good_flag.
// - after a clear the next error is loaded and flagged again.
// - later errors may queue and appear only after a clear.
// - bank count is in the capability register; bank zero at 400h.
// - a check raised while one is in progress enters shutdown.
module ebl_top
   import ebl_pkg::*;
#(
   parameter int BANKS = 4,
   parameter int DEPTH = 2
) (
   // clock and reset
   input  wire logic        REF_CLK,
   input  wire logic        RST_N,
   // avalon-mm slave
   input  wire logic [11:0] AVS_ADDRESS,
   input  wire logic        AVS_READ,
   input  wire logic        AVS_WRITE,
   input  wire logic [31:0] AVS_WRITEDATA,
   input  wire logic [3:0]  AVS_BYTEENABLE,
   output logic [31:0]      AVS_READDATA,
   output logic             AVS_WAITREQUEST,
   // error detection
   input  wire logic [BANKS-1:0] ERR_VALID,
   input  wire ebl_err_s         ERR_INFO [BANKS],
   input  wire logic             ERR_RESTART_IP_GOOD,
   // core outputs
   output logic             CHECK_EXCEPTION,
   output logic             SHUTDOWN,
   output logic             IRQ
);
   logic [31:0]      stat_w  [BANKS];
   logic [31:0]      addr_w  [BANKS];
   logic [31:0]      extra_w [BANKS];
   logic [BANKS-1:0] good;
   logic [BANKS-1:0] stat_wr;
   logic [IRQ_W-1:0] irq_stat;
   logic [IRQ_W-1:0] irq_mask;
   logic             restart_ip_good;
   logic             in_prog;
   logic             shut;
   logic             take_exc;
   logic             ack;
   logic [31:0]      rdata;
   logic             stop_on_corr;
   logic [31:0]      next_rdata;
   logic [31:0]      bank_rd;
   logic [31:0]      gstat;

   // one-cycle answer: waitrequest high in the request cycle, low the next
   wire req      = AVS_READ || AVS_WRITE;
   assign AVS_WAITREQUEST = req && !ack;
   wire wr_take  = AVS_WRITE && ack;
   wire full_wr  = wr_take && (AVS_BYTEENABLE == 4'hf);

   wire in_bank  = (AVS_ADDRESS >= OFS_BANK_BASE) &&
                   (AVS_ADDRESS < OFS_BANK_BASE + 12'(BANKS) * OFS_BANK_STEP);
   wire [11:0] boff  = AVS_ADDRESS - OFS_BANK_BASE;
   wire [7:0]  bidx  = boff[11:4];
   wire [11:0] breg  = {8'h00, boff[3:0]};

   wire [BANKS-1:0] err_unc;
   wire [BANKS-1:0] err_ok;
   genvar g;
   generate
      for (g = 0; g < BANKS; g++) begin : gb
         assign err_unc[g] = ERR_VALID[g] && ERR_INFO[g].uncorrected;
         assign err_ok[g]  = ERR_VALID[g] && !shut;
         assign stat_wr[g] = full_wr && in_bank && (bidx == 8'(g)) &&
                             (breg == OFS_BANK_STAT);
         ebl_bank #(.DEPTH(DEPTH)) u_bank (
            .clk        (REF_CLK),
            .rst_n      (RST_N),
            .err_valid  (err_ok[g]),
            .err_in     (ERR_INFO[g]),
            .stat_wr    (stat_wr[g]),
            .wdata      (AVS_WRITEDATA),
            .stat_word  (stat_w[g]),
            .addr_word  (addr_w[g]),
            .extra_word (extra_w[g]),
            .entry_good (good[g])
         );
      end
   endgenerate

   // only uncorrected errors raise the exception
   wire raise     = |err_unc && !shut;
   wire corrected = |(ERR_VALID & ~err_unc) && !shut;

   wire gstat_wr  = full_wr && (AVS_ADDRESS == OFS_GSTAT);
   wire clear_ip  = gstat_wr && !AVS_WRITEDATA[BIT_CHECK_IN_PROG];

   ebl_check u_check (
      .clk           (REF_CLK),
      .rst_n         (RST_N),
      .raise         (raise),
      .clear_in_prog (clear_ip),
      .in_prog       (in_prog),
      .shutdown      (shut),
      .take_exc      (take_exc)
   );

   wire [IRQ_W-1:0] events = {shut && !SHUTDOWN, take_exc, corrected};
   wire irq_clr_wr  = full_wr && (AVS_ADDRESS == OFS_IRQ_STAT);
   wire [IRQ_W-1:0] clr_bits = irq_clr_wr ? AVS_WRITEDATA[IRQ_W-1:0] : '0;

   always_ff @(posedge REF_CLK) begin
      if (!RST_N) begin
         ack             <= 1'b0;
         rdata           <= RST_WORD;
         irq_stat        <= '0;
         irq_mask        <= '0;
         restart_ip_good <= 1'b0;
         stop_on_corr    <= 1'b0;
         CHECK_EXCEPTION <= 1'b0;
         SHUTDOWN        <= 1'b0;
      end else begin
         ack             <= req && !ack;
         rdata           <= next_rdata;
         // set wins over a write-one clear
         irq_stat        <= (irq_stat & ~clr_bits) | events;
         CHECK_EXCEPTION <= take_exc;
         SHUTDOWN        <= shut;
         if (take_exc)
            restart_ip_good <= ERR_RESTART_IP_GOOD;
         if (full_wr && AVS_ADDRESS == OFS_IRQ_MASK)
            irq_mask <= AVS_WRITEDATA[IRQ_W-1:0];
         if (full_wr && AVS_ADDRESS == OFS_CTRL)
            stop_on_corr <= AVS_WRITEDATA[0];
      end
   end

   // register read selection
   always_comb begin
      gstat                      = '0;
      gstat[BIT_RESTART_IP_GOOD] = restart_ip_good;
      gstat[BIT_CHECK_IN_PROG]   = in_prog;
      gstat[BIT_SHUTDOWN]        = shut;
      bank_rd = UNMAPPED;
      for (int i = 0; i < BANKS; i++) begin
         if (bidx == 8'(i)) begin
            case (breg)
               OFS_BANK_STAT:  bank_rd = stat_w[i];
               OFS_BANK_ADDR:  bank_rd = addr_w[i];
               OFS_BANK_EXTRA: bank_rd = extra_w[i];
               default:        bank_rd = UNMAPPED;
            endcase
         end
      end
      next_rdata = UNMAPPED;
      if (AVS_READ && !ack) begin
         if (in_bank)
            next_rdata = bank_rd;
         else begin
            case (AVS_ADDRESS)
               OFS_CAP:      next_rdata = 32'(BANKS);
               OFS_GSTAT:    next_rdata = gstat;
               OFS_IRQ_STAT: next_rdata = 32'(irq_stat);
               OFS_IRQ_MASK: next_rdata = 32'(irq_mask);
               OFS_CTRL:     next_rdata = {31'h0, stop_on_corr};
               default:      next_rdata = UNMAPPED;
            endcase
         end
      end
   end

   // corrected errors go out as an interrupt only, never an exception
   // ctrl bit 0 holds the interrupt off while no bank holds an entry,
   // so a stale event with nothing left to log does not wake software
   wire hold = stop_on_corr && !(|good);
   assign IRQ          = |(irq_stat & irq_mask) && !hold;
   assign AVS_READDATA = rdata;

endmodule

// ### sim/ebl_top_asserts.sv
`timescale 1ns/1ns
module ebl_top_asserts
   import ebl_pkg::*;
#(
   parameter int BANKS = 4,
   parameter int DEPTH = 2
) (
   // clock and reset
   input wire logic             REF_CLK,
   input wire logic             RST_N,
   // avalon-mm slave
   input wire logic [11:0]      AVS_ADDRESS,
   input wire logic             AVS_READ,
   input wire logic             AVS_WRITE,
   input wire logic [31:0]      AVS_WRITEDATA,
   input wire logic [3:0]       AVS_BYTEENABLE,
   input wire logic [31:0]      AVS_READDATA,
   input wire logic             AVS_WAITREQUEST,
   // error detection
   input wire logic [BANKS-1:0] ERR_VALID,
   input wire ebl_err_s         ERR_INFO [BANKS],
   input wire logic             ERR_RESTART_IP_GOOD,
   // core outputs
   input wire logic             CHECK_EXCEPTION,
   input wire logic             SHUTDOWN,
   input wire logic             IRQ
);
   logic [BANKS-1:0] unc_v;
   logic             unc_any;
   logic             req;
   for (genvar i = 0; i < BANKS; i++) begin : g_unc
      assign unc_v[i] = ERR_VALID[i] & ERR_INFO[i].uncorrected;
   end
   assign unc_any = |unc_v;
   assign req     = AVS_READ | AVS_WRITE;

   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RST_N);

   // a fresh request sees exactly one wait cycle
   sequence s_req_start;
      req && !$past(req);
   endsequence
   sequence s_one_wait;
      AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
   endsequence

   wait_one_a: assert property (s_req_start |-> s_one_wait)
      else $error("bus answer not after one wait cycle");
   wait_idle_a: assert property (!req |-> !AVS_WAITREQUEST)
      else $error("waitrequest without request");
   unmapped_zero_a: assert property (AVS_READ && !AVS_WAITREQUEST &&
      AVS_ADDRESS inside {[12'h020:12'h3fc]} |-> AVS_READDATA == 32'h0)
      else $error("unmapped read not zero");
   corr_no_exc_a: assert property (!unc_any |=> !CHECK_EXCEPTION)
      else $error("exception without uncorrected error");
   exc_pulse_a: assert property (CHECK_EXCEPTION |=> !CHECK_EXCEPTION)
      else $error("exception longer than one cycle");
   shut_hold_a: assert property (SHUTDOWN |=> SHUTDOWN)
      else $error("shutdown dropped");
   shut_cause_a: assert property ($rose(SHUTDOWN) |->
      $past(unc_any) || $past(unc_any, 2))
      else $error("shutdown without uncorrected error");
   reset_quiet_a: assert property ($past(!RST_N) |->
      !IRQ && !SHUTDOWN && !CHECK_EXCEPTION)
      else $error("outputs active after reset");
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ns
module testbench;
   import ebl_pkg::*;
   localparam int BANKS = 4;
   localparam int DEPTH = 2;
   logic             REF_CLK, RST_N, AVS_READ, AVS_WRITE, AVS_WAITREQUEST;
   logic [11:0]      AVS_ADDRESS;
   logic [31:0]      AVS_WRITEDATA, AVS_READDATA, q;
   logic [3:0]       AVS_BYTEENABLE;
   logic [BANKS-1:0] ERR_VALID;
   ebl_err_s         ERR_INFO [BANKS];
   ebl_err_s         e, f;
   logic             ERR_RESTART_IP_GOOD, CHECK_EXCEPTION, SHUTDOWN, IRQ;
   int               n_errors = 0, n_tests = 0, cyc = 0, seen = 0;
   int               stamp [BANKS];

   ebl_top #(.BANKS(BANKS), .DEPTH(DEPTH)) dut (.REF_CLK(REF_CLK), .RST_N(RST_N),
      .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
      .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
      .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
      .ERR_VALID(ERR_VALID), .ERR_INFO(ERR_INFO), .ERR_RESTART_IP_GOOD(ERR_RESTART_IP_GOOD),
      .CHECK_EXCEPTION(CHECK_EXCEPTION), .SHUTDOWN(SHUTDOWN), .IRQ(IRQ));

   initial begin
      REF_CLK = 1'b0;
      forever #2 REF_CLK = ~REF_CLK;
   end
   // the ceiling of 20000 cycles is more than fifty times the length of the planned sequence
   always @(posedge REF_CLK) begin
      cyc <= cyc + 1;
      if (CHECK_EXCEPTION === 1'b1) seen <= seen + 1;
      if (cyc == 20000) begin
         n_errors++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("errors %0d tests %0d", n_errors, n_tests);
      if (n_errors == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // request held until the edge that samples waitrequest low
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge REF_CLK);
      AVS_ADDRESS <= a;
      AVS_WRITEDATA <= d;
      AVS_WRITE <= w;
      AVS_READ <= !w;
      do @(posedge REF_CLK); while (AVS_WAITREQUEST !== 1'b0);
      q = AVS_READDATA;
      AVS_READ <= 1'b0;
      AVS_WRITE <= 1'b0;
   endtask
   // irq follows registers that move at the edge, so look one edge later
   task automatic chk_irq(input logic exp);
      @(posedge REF_CLK);
      chk(32'(IRQ), 32'(exp));
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(q, exp);
   endtask
   task automatic err(input int b, input ebl_err_s x);
      @(posedge REF_CLK);
      ERR_INFO[b] <= x;
      ERR_VALID <= BANKS'(1) << b;
      @(posedge REF_CLK);
      ERR_VALID <= '0;
      repeat (3) @(posedge REF_CLK);
   endtask
   function automatic logic [11:0] ba(input int b, input logic [11:0] o);
      return OFS_BANK_BASE + OFS_BANK_STEP * 12'(b) + o;
   endfunction
   function automatic ebl_err_s rnd(input logic u);
      ebl_err_s x;
      x = {4'($urandom), 16'($urandom), 32'($urandom), 32'($urandom)};
      x.uncorrected = u;
      return x;
   endfunction
   function automatic logic [31:0] stat(input ebl_err_s x);
      logic [31:0] s;
      s = 32'(x.code);
      s[BIT_ENTRY_GOOD] = 1'b1;
      s[BIT_UNCORRECTED] = x.uncorrected;
      s[BIT_EXTRA_GOOD] = x.extra_good;
      s[BIT_ADDR_GOOD] = x.addr_good;
      s[BIT_CTX_CORRUPT] = x.ctx_corrupt;
      return s;
   endfunction
   // address and extra words only mean something when flagged
   task automatic chk_bank(input int b, input ebl_err_s x);
      rd(ba(b, OFS_BANK_STAT), stat(x));
      if (x.addr_good) rd(ba(b, OFS_BANK_ADDR), x.addr);
      if (x.extra_good) rd(ba(b, OFS_BANK_EXTRA), x.extra);
   endtask

   initial begin
      RST_N = 1'b0;
      AVS_ADDRESS = '0;
      AVS_READ = 1'b0;
      AVS_WRITE = 1'b0;
      AVS_WRITEDATA = '0;
      AVS_BYTEENABLE = 4'hf;
      ERR_VALID = '0;
      ERR_RESTART_IP_GOOD = 1'b0;
      foreach (ERR_INFO[i]) ERR_INFO[i] = '0;
      q = $urandom(32'he710);
      repeat (10) @(posedge REF_CLK);
      RST_N <= 1'b1;
      rd(OFS_CAP, 32'(BANKS));
      rd(OFS_GSTAT, RST_WORD);
      rd(12'h020, UNMAPPED);
      for (int b = 0; b < BANKS; b++) rd(ba(b, OFS_BANK_STAT), RST_WORD);
      bus(1'b1, OFS_IRQ_MASK, 32'h1);
      for (int b = 0; b < BANKS; b++) begin
         e = rnd(1'b0);
         err(b, e);
         chk_bank(b, e);
         stamp[b] = cyc;
         bus(1'b1, ba(b, OFS_BANK_STAT), 32'h1);
         AVS_BYTEENABLE <= 4'h3;
         bus(1'b1, ba(b, OFS_BANK_STAT), 32'h0);
         AVS_BYTEENABLE <= 4'hf;
         rd(ba(b, OFS_BANK_STAT), stat(e));
         chk(32'(IRQ), 32'h1);
         bus(1'b1, OFS_IRQ_STAT, 32'h1);
         rd(OFS_IRQ_STAT, 32'h0);
         chk(32'(IRQ), 32'h0);
         bus(1'b1, ba(b, OFS_BANK_STAT), 32'h0);
         rd(ba(b, OFS_BANK_STAT), 32'h0);
      end
      for (int b = 1; b < BANKS; b++) chk(32'(stamp[b] > stamp[b - 1]), 32'h1);
      chk(32'(seen), 32'h0);
      e = rnd(1'b0);
      f = rnd(1'b0);
      err(0, e);
      err(0, f);
      rd(ba(0, OFS_BANK_STAT), stat(e));
      bus(1'b1, ba(0, OFS_BANK_STAT), 32'h0);
      chk_bank(0, f);
      repeat (DEPTH + 2) err(0, rnd(1'b0));
      bus(1'b0, ba(0, OFS_BANK_STAT), 32'h0);
      chk(32'(q[BIT_LOST_ERROR]), 32'h1);
      repeat (DEPTH + 3) bus(1'b1, ba(0, OFS_BANK_STAT), 32'h0);
      rd(ba(0, OFS_BANK_STAT), 32'h0);
      chk_irq(1'b1);
      bus(1'b1, OFS_CTRL, 32'h1);
      rd(OFS_CTRL, 32'h1);
      chk_irq(1'b0);
      bus(1'b1, OFS_CTRL, 32'h0);
      chk_irq(1'b1);
      ERR_RESTART_IP_GOOD <= 1'b1;
      e = rnd(1'b1);
      e.ctx_corrupt = 1'b1;
      err(1, e);
      chk(32'(seen), 32'h1);
      rd(OFS_GSTAT, 32'h5);
      chk_bank(1, e);
      bus(1'b1, OFS_GSTAT, 32'h0);
      bus(1'b0, OFS_GSTAT, 32'h0);
      chk(32'(q[BIT_CHECK_IN_PROG]), 32'h0);
      ERR_RESTART_IP_GOOD <= 1'b0;
      err(2, rnd(1'b1));
      chk(32'(seen), 32'h2);
      rd(OFS_GSTAT, 32'h4);
      if (q[BIT_CHECK_IN_PROG] && !q[BIT_RESTART_IP_GOOD])
         $display("console: bank 2 error is not restartable");
      bus(1'b1, OFS_IRQ_STAT, 32'h1);
      chk_irq(1'b0);
      bus(1'b1, OFS_IRQ_MASK, 32'h2);
      chk_irq(1'b1);
      bus(1'b1, OFS_IRQ_STAT, 32'h6);
      chk_irq(1'b0);
      err(3, rnd(1'b1));
      chk(32'(SHUTDOWN), 32'h1);
      chk(32'(seen), 32'h2);
      bus(1'b0, OFS_GSTAT, 32'h0);
      chk(32'(q[BIT_SHUTDOWN]), 32'h1);
      stop_test();
   end
endmodule

bind ebl_top ebl_top_asserts #(.BANKS(BANKS), .DEPTH(DEPTH)) u_chk (.REF_CLK(REF_CLK),
   .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
   .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(AVS_BYTEENABLE),
   .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .ERR_VALID(ERR_VALID), .ERR_INFO(ERR_INFO), .ERR_RESTART_IP_GOOD(ERR_RESTART_IP_GOOD),
   .CHECK_EXCEPTION(CHECK_EXCEPTION), .SHUTDOWN(SHUTDOWN), .IRQ(IRQ));
